/* bench/epl_host.sv */
// Purpose: host command model for the position latch
// Assumes: commands change on the falling edge
// Notes:   strobes last one cycle, as the latch takes them
`timescale 1ns/1ns
// ==========
// host model
module epl_host (
   input  wire logic         i_clk_sys,
   output epl_pkg::epl_arm_t o_arm,
   output epl_pkg::epl_rpt_t o_rpt
);
   initial begin
      o_arm = '0;
      o_rpt = '0;
   end
   // re-arming after a capture is left to the host, the latch never does it alone
   task automatic arm_axis(input logic [2:0] ax, input epl_pkg::epl_src_t src);
      @(negedge i_clk_sys);
      o_arm = '{arm: 1'h1, axis: ax, src: src};
      @(negedge i_clk_sys);
      o_arm.arm = 1'h0;
   endtask
   task automatic report_axis(input logic [2:0] ax);
      @(negedge i_clk_sys);
      o_rpt = '{req: 1'h1, axis: ax};
      @(negedge i_clk_sys);
      o_rpt.req = 1'h0;
   endtask
endmodule

/* bench/epl_latch_chk.sv */
// Purpose: port assertions for the position latch
// Assumes: one clock domain
// Notes:   bound to every latch instance
`timescale 1ns/1ns
// ==========
// checker
module epl_latch_chk #(
   parameter int N_AXES = 8,
   parameter int POS_W  = 32
) (
   input wire logic              i_clk_sys,
   input wire logic              i_rst,
   input wire epl_pkg::epl_arm_t i_arm_capture_cmd,
   input wire epl_pkg::epl_rpt_t i_report_capture_cmd,
   input wire logic [N_AXES-1:0] o_capture_pending_flag,
   input wire logic [N_AXES-1:0] o_capture_done,
   input wire logic [POS_W-1:0]  o_captured_position_readout,
   input wire logic              o_readout_valid
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   sequence rpt_s;
      i_report_capture_cmd.req ##2 o_readout_valid;
   endsequence
   arm_pend_a: assert property (i_arm_capture_cmd.arm |=>
      o_capture_pending_flag[$past(i_arm_capture_cmd.axis)]) else $error("arm not pending");
   arm_clr_a: assert property (i_arm_capture_cmd.arm |=>
      !o_capture_done[$past(i_arm_capture_cmd.axis)]) else $error("arm kept done");
   rpt_val_a: assert property (i_report_capture_cmd.req |-> rpt_s)
      else $error("report not answered");
   val_cause_a: assert property (o_readout_valid |-> $past(i_report_capture_cmd.req, 2))
      else $error("stray readout");
   pend_drop_a: assert property (($past(o_capture_pending_flag) & ~o_capture_pending_flag
      & ~o_capture_done) == '0) else $error("pending lost");
   done_rise_a: assert property ((o_capture_done & ~$past(o_capture_done)
      & ~$past(o_capture_pending_flag)) == '0) else $error("unarmed capture");
   done_hold_a: assert property ((($past(o_capture_done) & ~o_capture_done) == '0)
      || $past(i_arm_capture_cmd.arm)) else $error("done dropped");
   data_hold_a: assert property (!o_readout_valid |-> $stable(o_captured_position_readout))
      else $error("readout moved");
   pend_done_a: assert property ((o_capture_pending_flag & o_capture_done) == '0)
      else $error("pending and done together");
endmodule
bind epl_latch epl_latch_chk #(.N_AXES(N_AXES), .POS_W(POS_W)) u_chk (
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_arm_capture_cmd(i_arm_capture_cmd),
   .i_report_capture_cmd(i_report_capture_cmd),
   .o_capture_pending_flag(o_capture_pending_flag), .o_capture_done(o_capture_done),
   .o_captured_position_readout(o_captured_position_readout),
   .o_readout_valid(o_readout_valid));

/* bench/tb_encoder_position_latch.sv */
// Purpose: self-checking bench for the position latch
// Assumes: 50 MHz clock, inputs driven on the falling edge
// Notes:   counts held steady around each capture
`timescale 1ns/1ns
// ==========
// bench top
module tb_encoder_position_latch;
   logic              i_clk_sys = 1'h0;
   logic              i_rst     = 1'h1;
   logic [7:0]        pin       = 8'hff;
   logic [7:0]        pol       = 8'h00;
   logic [255:0]      mcnt, acnt;
   logic [7:0]        pend, done;
   logic [31:0]       rdat;
   logic              rval;
   epl_pkg::epl_arm_t arm;
   epl_pkg::epl_rpt_t rpt;
   int                errors = 0;
   int                check_count = 0;
   always #10 i_clk_sys = ~i_clk_sys;
   epl_host u_host (.i_clk_sys(i_clk_sys), .o_arm(arm), .o_rpt(rpt));
   epl_latch u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_axis_a_capture_input(pin[0]), .i_axis_b_capture_input(pin[1]),
      .i_axis_c_capture_input(pin[2]), .i_axis_d_capture_input(pin[3]),
      .i_axis_e_capture_input(pin[4]), .i_axis_f_capture_input(pin[5]),
      .i_axis_g_capture_input(pin[6]), .i_axis_h_capture_input(pin[7]),
      .i_capture_active_high(pol), .i_main_count(mcnt), .i_aux_count(acnt),
      .i_arm_capture_cmd(arm), .i_report_capture_cmd(rpt),
      .o_capture_pending_flag(pend), .o_capture_done(done),
      .o_captured_position_readout(rdat), .o_readout_valid(rval));
   function automatic logic [31:0] val(input int k, input logic s);
      return {s ? 16'haaaa : 16'h5555, 16'(k)};
   endfunction
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // bound on the wait doubles as the latency limit
   task automatic cap(input int k, input int lim);
      int n;
      n = 0;
      @(negedge i_clk_sys);
      pin[k] = ~pin[k];
      while (done[k] !== 1'h1 && n < lim) begin
         @(negedge i_clk_sys);
         n++;
      end
      chk(32'(n < lim), 32'h1);
      if (n >= lim) print_verdict();
   endtask
   // valid pulse and data stand two cycles after the request is taken
   task automatic rd(input int k, input logic [31:0] e);
      u_host.report_axis(3'(k));
      @(negedge i_clk_sys);
      chk(32'(rval), 32'h1);
      chk(rdat, e);
   endtask
   task automatic t_each_axis();
      for (int k = 0; k < 8; k++) begin
         u_host.arm_axis(3'(k), epl_pkg::EPL_SRC_MAIN);
         chk({pend[k], done[k]}, 32'h2);
         cap(k, 600);
         chk(32'(pend[k]), 32'h0);
         rd(k, val(k, 1'h0));
      end
   endtask
   task automatic t_aux_high();
      pol[2] = 1'h1;
      u_host.arm_axis(3'h2, epl_pkg::EPL_SRC_AUX);
      cap(2, 1750);
      rd(2, val(2, 1'h1));
   endtask
   // three axes fire in one cycle and must share the single store port
   task automatic t_tie();
      int n;
      n = 0;
      pol = pol | 8'ha1;
      u_host.arm_axis(3'h0, epl_pkg::EPL_SRC_MAIN);
      u_host.arm_axis(3'h5, epl_pkg::EPL_SRC_AUX);
      u_host.arm_axis(3'h7, epl_pkg::EPL_SRC_MAIN);
      chk({pend[7], pend[5], pend[0]}, 32'h7);
      @(negedge i_clk_sys);
      pin = pin ^ 8'ha1;
      while ({done[7], done[5], done[0]} !== 3'h7 && n < 1750) begin
         @(negedge i_clk_sys);
         n++;
      end
      chk(32'(n < 1750), 32'h1);
      if (n >= 1750) print_verdict();
      chk({pend[7], pend[5], pend[0]}, 32'h0);
      rd(0, ~val(0, 1'h0));
      rd(5, ~val(5, 1'h1));
      rd(7, ~val(7, 1'h0));
   endtask
   task automatic t_once();
      mcnt = ~mcnt;
      acnt = ~acnt;
      repeat (3) begin
         @(negedge i_clk_sys);
         pin[2] = ~pin[2];
         repeat (6) @(negedge i_clk_sys);
      end
      chk({pend[2], done[2]}, 32'h1);
      rd(2, val(2, 1'h1));
      u_host.arm_axis(3'h2, epl_pkg::EPL_SRC_AUX);
      chk({pend[2], done[2]}, 32'h2);
      cap(2, 1750);
      rd(2, ~val(2, 1'h1));
   endtask
   initial begin
      for (int k = 0; k < 8; k++) begin
         mcnt[k*32+:32] = val(k, 1'h0);
         acnt[k*32+:32] = val(k, 1'h1);
      end
      repeat (3) @(negedge i_clk_sys);
      i_rst = 1'h0;
      t_each_axis();
      t_aux_high();
      t_once();
      t_tie();
      print_verdict();
   end
endmodule

/* core/epl_latch.sv */
// Purpose: eight-axis high-speed encoder position latch
// Assumes: encoder counts are synchronous to i_clk_sys
// Notes:   capture inputs are pins and are synchronised first
//
// Function
// - capture the axis main or auxiliary count when its capture input changes
// - trigger polarity selectable: fire on input going high or going low
// - active-low capture completes within 12 microseconds of the transition
// - active-high capture completes within 35 microseconds of the transition
// - inputs one to four serve axes A-D, nine to twelve serve E-H
// - software arms each axis, choosing main or auxiliary encoder
// - pending flag reads 1 while armed and not yet captured
// - report command returns the captured count of the requested axis
// - one capture per arm; later transitions ignored until re-armed
`timescale 1ns/1ns
`include "epl_map.svh"
module epl_latch #(
   parameter int N_AXES = `EPL_N_AXES,
   parameter int POS_W  = `EPL_POS_W
) (
   // clock and reset
   input  wire logic                    i_clk_sys,
   input  wire logic                    i_rst,
   // capture pins
   input  wire logic                    i_axis_a_capture_input,
   input  wire logic                    i_axis_b_capture_input,
   input  wire logic                    i_axis_c_capture_input,
   input  wire logic                    i_axis_d_capture_input,
   input  wire logic                    i_axis_e_capture_input,
   input  wire logic                    i_axis_f_capture_input,
   input  wire logic                    i_axis_g_capture_input,
   input  wire logic                    i_axis_h_capture_input,
   // polarity, per axis: 1 fires on rising, 0 on falling
   input  wire logic [N_AXES-1:0]       i_capture_active_high,
   // encoder counts, axis k in slice k
   input  wire logic [N_AXES*POS_W-1:0] i_main_count,
   input  wire logic [N_AXES*POS_W-1:0] i_aux_count,
   // commands
   input  wire epl_pkg::epl_arm_t       i_arm_capture_cmd,
   input  wire epl_pkg::epl_rpt_t       i_report_capture_cmd,
   // status and readback
   output logic      [N_AXES-1:0]       o_capture_pending_flag,
   output logic      [N_AXES-1:0]       o_capture_done,
   output logic      [POS_W-1:0]        o_captured_position_readout,
   output logic                         o_readout_valid
);
   localparam int AW = $clog2(N_AXES);

   // eight capture pins are fixed, so no other axis count can be served
   if (N_AXES != 8) begin : g_bad_axes
      $error("epl_latch: N_AXES must be 8");
   end
   if (POS_W < 1) begin : g_bad_width
      $error("epl_latch: POS_W must be positive");
   end

   // ==========================================================
   // pin synchronisers
   // ==========================================================
   logic [N_AXES-1:0] pin_raw;
   logic [N_AXES-1:0] sync1_r;
   logic [N_AXES-1:0] sync2_r;
   logic [N_AXES-1:0] prev_r;
   logic [1:0]        settle_r;
   logic [1:0]        settle_nxt;
   logic              edges_ok;

   always_comb begin
      pin_raw = {i_axis_h_capture_input, i_axis_g_capture_input,
                 i_axis_f_capture_input, i_axis_e_capture_input,
                 i_axis_d_capture_input, i_axis_c_capture_input,
                 i_axis_b_capture_input, i_axis_a_capture_input};
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         sync1_r  <= '0;
         sync2_r  <= '0;
         prev_r   <= '0;
         settle_r <= 2'h0;
      end else begin
         sync1_r  <= pin_raw;
         sync2_r  <= sync1_r;
         prev_r   <= sync2_r;
         settle_r <= settle_nxt;
      end
   end

   // reset zeros in the chain are not pin levels: hide edges until it refills,
   // so a pin idling high gives no false edge after reset
   always_comb begin
      settle_nxt = (settle_r == 2'(`EPL_SETTLE_CYC)) ? settle_r : 2'(settle_r + 2'h1);
      edges_ok   = (settle_r == 2'(`EPL_SETTLE_CYC));
   end

   // ==========================================================
   // per-axis arm and capture
   // ==========================================================
   // an uncontested capture lands three edges after the pin edge,
   // far inside both latency limits
   logic [N_AXES-1:0] armed_r;
   logic [N_AXES-1:0] armed_nxt;
   logic [N_AXES-1:0] done_r;
   logic [N_AXES-1:0] done_nxt;
   logic [N_AXES-1:0] aux_sel_r;
   logic [N_AXES-1:0] aux_sel_nxt;
   logic [N_AXES-1:0] held_r;
   logic [N_AXES-1:0] held_nxt;
   logic [N_AXES-1:0] want;
   logic [N_AXES-1:0] grant;
   logic              we;
   logic [AW-1:0]     waddr;
   logic [POS_W-1:0]  wdata;

   for (genvar k = 0; k < N_AXES; k++) begin : g_axis
      logic rise;
      logic fall;
      logic arm_here;
      logic edge_hit;
      assign rise     = edges_ok & sync2_r[k] & ~prev_r[k];
      assign fall     = edges_ok & ~sync2_r[k] & prev_r[k];
      assign arm_here = i_arm_capture_cmd.arm && (i_arm_capture_cmd.axis == AW'(k));
      assign edge_hit = armed_r[k] & (i_capture_active_high[k] ? rise : fall);
      // an arm in the same cycle discards the event
      assign want[k]  = ~arm_here & (edge_hit | held_r[k]);

      always_comb begin
         armed_nxt[k]   = armed_r[k];
         done_nxt[k]    = done_r[k];
         aux_sel_nxt[k] = aux_sel_r[k];
         held_nxt[k]    = held_r[k];
         if (arm_here) begin
            armed_nxt[k]   = 1'b1;
            done_nxt[k]    = 1'b0;
            held_nxt[k]    = 1'b0;
            aux_sel_nxt[k] = (i_arm_capture_cmd.src == epl_pkg::EPL_SRC_AUX);
         end else if (grant[k]) begin
            armed_nxt[k] = 1'b0;
            done_nxt[k]  = 1'b1;
            held_nxt[k]  = 1'b0;
         end else if (want[k]) begin
            // lost the store port: keep the event, stay pending
            held_nxt[k]  = 1'b1;
         end
      end
   end

   // store is single-port: lowest axis wins a same-cycle tie, the others
   // are held and served on later edges; trade-off is that a held axis
   // samples its count up to seven cycles late, still inside both limits
   always_comb begin
      grant = '0;
      we    = 1'b0;
      waddr = '0;
      wdata = '0;
      for (int k = N_AXES - 1; k >= 0; k--) begin
         if (want[k]) begin
            grant    = '0;
            grant[k] = 1'b1;
            we       = 1'b1;
            waddr    = AW'(k);
            wdata    = aux_sel_r[k] ? i_aux_count[k*POS_W +: POS_W]
                                    : i_main_count[k*POS_W +: POS_W];
         end
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         armed_r   <= '0;
         done_r    <= '0;
         aux_sel_r <= '0;
         held_r    <= '0;
      end else begin
         armed_r   <= armed_nxt;
         done_r    <= done_nxt;
         aux_sel_r <= aux_sel_nxt;
         held_r    <= held_nxt;
      end
   end

   // ==========================================================
   // holding store and readback
   // ==========================================================
   logic [POS_W-1:0] rdata;
   logic             rvalid_nxt;

   epl_store #(.W(POS_W), .N(N_AXES)) u_store (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_we      (we),
      .i_waddr   (waddr),
      .i_wdata   (wdata),
      .i_re      (i_report_capture_cmd.req),
      .i_raddr   (i_report_capture_cmd.axis),
      .o_rdata   (rdata)
   );

   always_comb begin
      rvalid_nxt = i_report_capture_cmd.req;
   end

   // ==========================================================
   // output registers
   // ==========================================================
   logic rvalid_r;
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         rvalid_r                    <= 1'b0;
         o_readout_valid             <= 1'b0;
         o_captured_position_readout <= POS_W'(`EPL_POS_RESET);
         o_capture_pending_flag      <= '0;
         o_capture_done              <= '0;
      end else begin
         rvalid_r                    <= rvalid_nxt;
         o_readout_valid             <= rvalid_r;
         o_captured_position_readout <= rdata;
         o_capture_pending_flag      <= armed_nxt;
         o_capture_done              <= done_nxt;
      end
   end
endmodule

/* core/epl_map.svh */
// Purpose: constants for the encoder position latch
// Assumes: 50 MHz system clock
// Notes:   times in ns, latency cycle counts derived from them
`ifndef EPL_MAP_SVH
`define EPL_MAP_SVH

`define EPL_CLK_PERIOD_NS   20
`define EPL_LOW_LAT_NS      12000
`define EPL_HIGH_LAT_NS     35000
`define EPL_LOW_LAT_CYC     (`EPL_LOW_LAT_NS / `EPL_CLK_PERIOD_NS)
`define EPL_HIGH_LAT_CYC    (`EPL_HIGH_LAT_NS / `EPL_CLK_PERIOD_NS)
`define EPL_SETTLE_CYC      3
`define EPL_N_AXES          8
`define EPL_POS_W           32
`define EPL_POS_RESET       32'h0000_0000

`endif

/* core/epl_pkg.sv */
// Purpose: shared types for the encoder position latch
// Assumes: nothing
// Notes:   none
package epl_pkg;
   typedef enum logic {EPL_SRC_MAIN, EPL_SRC_AUX} epl_src_t;
   typedef struct packed {
      logic       arm;        // one-cycle arm strobe
      logic [2:0] axis;
      epl_src_t   src;
   } epl_arm_t;
   typedef struct packed {
      logic       req;        // one-cycle report strobe
      logic [2:0] axis;
   } epl_rpt_t;
endpackage

/* core/epl_store.sv */
// Purpose: per-axis holding store for captured counts
// Assumes: one write port, one registered read port
// Notes:   read data appear one cycle after the read strobe
`timescale 1ns/1ns
module epl_store #(
   parameter int W = 32,
   parameter int N = 8
) (
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_rst,
   // write
   input  wire logic                 i_we,
   input  wire logic [$clog2(N)-1:0] i_waddr,
   input  wire logic [W-1:0]         i_wdata,
   // read
   input  wire logic                 i_re,
   input  wire logic [$clog2(N)-1:0] i_raddr,
   output logic      [W-1:0]         o_rdata
);
   logic [W-1:0] mem_r [N];
   logic [W-1:0] rdata_nxt;

   if (N < 2 || W < 1) begin : g_bad_shape
      $error("epl_store: N must be at least 2 and W positive");
   end

   always_comb begin
      rdata_nxt = i_re ? mem_r[i_raddr] : o_rdata;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_we) begin
         mem_r[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= rdata_nxt;
      end
   end
endmodule
